// [ptbg_core.sv]
/*
 * Time base, chop clock and generator control of one pwm generator.
 * Assumes event inputs come from logic on ref_clk; the compensation pin is
 * asynchronous. Pin control, fault logic and dead-time units sit outside.
 */
// Operation
// [R01] 16-bit master period sets master time base
// [R02] Counter matching compare value yields match event
// [R03] Chop enable bit starts and stops chop
// [R04] Chop rate is tick rate over divider+1
// [R05] Duty source bit selects shared or own duty
// [R06] Fault event sets flag; enable write 0 clears
// [R07] Current-limit event sets flag; enable 0 clears
// [R08] Enabled trigger sets flag; enable 0 clears
// [R09] Software clears flag here and in controller
// [R10] Independent mode uses phase as own period
// [R11] Software keeps mode bits fixed while enabled
// [R12] Two-bit field selects the dead-time mode
// [R13] Compensation polarity only used in mode 11
// [R14] Compensation input picks shortened and lengthened output
// [R15] Center-aligned only when independent mode is active
// [R16] External reset by current-limit in independent mode
// [R17] Software sets independent mode, clears limit mode
// [R18] Immediate update, else update at period boundary
// [R19] Unimplemented bits read zero, ignore writes
// [R20] Module enable starts all time bases
// [R21] Prescaler divides by 1 to 64, reset 1
// [R22] Interrupt request when pending and enabled
`timescale 1ns/1ps
module ptbg_core
    import ptbg_pkg::*;
(
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            nrst,
    // Register port
    input  wire logic [AW-1:0]   addr,
    input  wire logic [DW-1:0]   wr_data,
    input  wire logic            wr_stb,
    input  wire logic            rd_stb,
    output logic      [DW-1:0]   rd_data,
    // Events and external inputs
    input  wire logic            fault_evt,
    input  wire logic            curlimit_evt,
    input  wire logic            trigger_evt,
    input  wire logic            curlimit_src,
    input  wire logic            curlimit_mode,
    input  wire logic            deadtime_comp_input,
    // Results
    output logic                 irq,
    output logic                 chop_clk,
    output logic                 sevt_match,
    output logic                 period_bnd,
    output logic                 center_mode,
    output logic      [15:0]     gen_count,
    output ptbg_act_t            act,
    output ptbg_dt_t             dt_ctl
);
    logic [15:0] period_r, sevt_r, chop_r, mduty_r, gctl_r, mctl_r;
    logic [15:0] gduty_r, phase_r, dtv_r, altdt_r;
    logic [2:0]  pend_r;
    logic [15:0] rd_data_r;
    logic        irq_r, chop_clk_r, sevt_r2, bnd_r, cam_r;
    logic [6:0]  pre_cnt_r;
    logic [9:0]  chop_cnt_r;
    logic [15:0] mtb_r, gcnt_r;
    ptbg_dir_t   dir_r;
    ptbg_act_t   act_r;
    ptbg_dt_t    dt_r;
    logic        cmp_s1_r, cmp_s2_r;

    // Decode
    wire         wr_period  = wr_stb && addr == ADDR_PERIOD;
    wire         wr_sevt    = wr_stb && addr == ADDR_SEVT;
    wire         wr_chop    = wr_stb && addr == ADDR_CHOP;
    wire         wr_mduty   = wr_stb && addr == ADDR_MDUTY;
    wire         wr_gctl    = wr_stb && addr == ADDR_GCTL;
    wire         wr_mctl    = wr_stb && addr == ADDR_MCTL;
    wire         wr_gduty   = wr_stb && addr == ADDR_GDUTY;
    wire         wr_phase   = wr_stb && addr == ADDR_PHASE;
    wire         wr_dt      = wr_stb && addr == ADDR_DT;
    wire         wr_altdt   = wr_stb && addr == ADDR_ALTDT;

    wire         mod_en     = mctl_r[B_EN];
    wire         independent_period_mode        = gctl_r[B_ITB];
    wire [2:0]   ien        = {gctl_r[B_FLT_E], gctl_r[B_CL_E], gctl_r[B_TRG_E]};

    // Prescaler: code 111 falls back to divide-by-1
    wire [2:0]   pre_code   = (mctl_r[2:0] == PRE_RSVD) ? 3'h0 : mctl_r[2:0];
    wire [6:0]   pre_last   = 7'((7'h1 << pre_code) - 7'h1);                // [R21]
    wire         tick       = mod_en && pre_cnt_r >= pre_last;              // [R20]
    wire [6:0]   pre_nxt    = (!mod_en || tick) ? 7'h00 : 7'(pre_cnt_r + 7'h1);

    // Master time base
    wire         mtb_wrap   = tick && mtb_r >= period_r;                    // [R01]
    wire [15:0]  mtb_nxt    = !mod_en ? ZERO16 : mtb_wrap ? ZERO16
                            : tick ? 16'(mtb_r + 16'h1) : mtb_r;
    wire         sevt_nxt   = tick && mtb_r == sevt_r;                      // [R02]

    // Generator time base
    wire         cam_eff    = independent_period_mode && gctl_r[B_CAM];                         // [R15]
    wire         xreset     = independent_period_mode && gctl_r[B_EXTERNAL_PERIOD_RESET_ENABLE] && !curlimit_mode
                            && curlimit_src;                                // [R16]
    wire         g_top      = gcnt_r >= act_r.phase;                        // [R10]
    wire         g_bot      = gcnt_r == ZERO16;
    wire         g_wrap     = tick && (cam_eff ? (dir_r == CNT_DOWN && g_bot) : g_top);
    wire [15:0]  gcnt_nxt   = (!mod_en || xreset) ? ZERO16
                            : !independent_period_mode ? mtb_nxt
                            : !tick ? gcnt_r
                            : cam_eff ? (dir_r == CNT_UP ? (g_top ? 16'(gcnt_r - 16'h1)
                                                                  : 16'(gcnt_r + 16'h1))
                                                         : (g_bot ? 16'(gcnt_r + 16'h1)
                                                                  : 16'(gcnt_r - 16'h1)))
                            : g_top ? ZERO16 : 16'(gcnt_r + 16'h1);
    ptbg_dir_t   dir_nxt;
    always_comb begin
        dir_nxt = dir_r;
        case (dir_r)
            CNT_UP:   if (tick && cam_eff && g_top) dir_nxt = CNT_DOWN;
            CNT_DOWN: if (tick && g_bot) dir_nxt = CNT_UP;
            default:  dir_nxt = CNT_UP;
        endcase
        if (!mod_en || xreset || !cam_eff) dir_nxt = CNT_UP;
    end
    wire         bnd_nxt    = independent_period_mode ? (g_wrap || xreset) : mtb_wrap;

    // Active copies: immediate, at boundary, or while disabled
    wire         upd        = gctl_r[B_IUE] || bnd_nxt || !mod_en;          // [R18]
    ptbg_act_t   act_nxt;
    assign act_nxt.period       = independent_period_mode ? phase_r : period_r;                 // [R10]
    assign act_nxt.duty         = gctl_r[B_DUTY_SOURCE_SELECT] ? mduty_r : gduty_r;       // [R05]
    assign act_nxt.phase        = phase_r;
    assign act_nxt.deadtime     = dtv_r;
    assign act_nxt.alt_deadtime = altdt_r;

    // Dead-time control
    wire [1:0]   dtm        = gctl_r[B_DTM_HI:B_DTM_LO];                    // [R12]
    wire         comp_on    = dtm == DTM_COMP;                              // [R13]
    wire         sh_high    = gctl_r[B_DEADTIME_COMP_POLARITY] ? cmp_s2_r : !cmp_s2_r;        // [R14]
    ptbg_dt_t    dt_nxt;
    assign dt_nxt.mode         = dtm;
    assign dt_nxt.shorten_high = comp_on && sh_high;
    assign dt_nxt.shorten_low  = comp_on && !sh_high;

    // Chop clock: high for the first half of each divider period
    wire [9:0]   chop_div   = chop_r[9:0];
    wire         chop_on    = chop_r[B_EN] && mod_en;                       // [R03]
    wire         chop_end   = chop_cnt_r >= chop_div;
    wire [9:0]   chop_nxt   = !chop_on ? 10'h000 : !tick ? chop_cnt_r
                            : chop_end ? 10'h000 : 10'(chop_cnt_r + 10'h1); // [R04]
    wire [10:0]  chop_half  = 11'(({1'b0, chop_div} + 11'h1) >> 1);
    wire         chop_lvl   = chop_on && ({1'b0, chop_cnt_r} < chop_half);

    // Pending flags: event set wins over enable-cleared
    wire [2:0]   evt        = {fault_evt, curlimit_evt, trigger_evt && ien[0]}; // [R08]
    wire [2:0]   wien       = {wr_data[B_FLT_E], wr_data[B_CL_E], wr_data[B_TRG_E]};
    wire [2:0]   clr        = wr_gctl ? ~wien : 3'h0;
    wire [2:0]   pend_nxt   = (pend_r & ~clr) | evt;                        // [R06] [R07]
    wire         irq_nxt    = |(pend_nxt & (wr_gctl ? wien : ien));         // [R22]

    // Read mux
    wire [15:0]  gctl_rd    = {pend_r, gctl_r[12:0] & GCTL_WMASK[12:0]};    // [R19]
    logic [15:0] rd_mux;
    always_comb begin
        case (addr)
            ADDR_PERIOD: rd_mux = period_r;
            ADDR_SEVT:   rd_mux = sevt_r;
            ADDR_CHOP:   rd_mux = chop_r & CHOP_WMASK;                      // [R19]
            ADDR_MDUTY:  rd_mux = mduty_r;
            ADDR_GCTL:   rd_mux = gctl_rd;
            ADDR_MCTL:   rd_mux = mctl_r & MCTL_WMASK;
            ADDR_GDUTY:  rd_mux = gduty_r;
            ADDR_PHASE:  rd_mux = phase_r;
            ADDR_DT:     rd_mux = dtv_r & DT_WMASK;
            ADDR_ALTDT:  rd_mux = altdt_r & DT_WMASK;
            ADDR_TBCNT:  rd_mux = mtb_r;
            default:     rd_mux = ZERO16;
        endcase
    end
    wire [15:0]  rd_nxt     = rd_stb ? rd_mux : ZERO16;

    // Software registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            period_r <= PERIOD_RST;
            sevt_r   <= ZERO16;
            chop_r   <= ZERO16;
            mduty_r  <= ZERO16;
            gctl_r   <= ZERO16;
            mctl_r   <= ZERO16;
            gduty_r  <= ZERO16;
            phase_r  <= ZERO16;
            dtv_r    <= ZERO16;
            altdt_r  <= ZERO16;
        end else begin
            if (wr_period) period_r <= wr_data;
            if (wr_sevt)   sevt_r   <= wr_data;
            if (wr_chop)   chop_r   <= wr_data & CHOP_WMASK;                // [R19]
            if (wr_mduty)  mduty_r  <= wr_data;
            if (wr_gctl)   gctl_r   <= wr_data & GCTL_WMASK;                // [R19]
            if (wr_mctl)   mctl_r   <= wr_data & MCTL_WMASK;
            if (wr_gduty)  gduty_r  <= wr_data;
            if (wr_phase)  phase_r  <= wr_data;
            if (wr_dt)     dtv_r    <= wr_data & DT_WMASK;
            if (wr_altdt)  altdt_r  <= wr_data & DT_WMASK;
        end
    end

    // Counters and state
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pre_cnt_r  <= 7'h00;
            mtb_r      <= ZERO16;
            gcnt_r     <= ZERO16;
            dir_r      <= CNT_UP;
            chop_cnt_r <= 10'h000;
            pend_r     <= 3'h0;
        end else begin
            pre_cnt_r  <= pre_nxt;
            mtb_r      <= mtb_nxt;
            gcnt_r     <= gcnt_nxt;
            dir_r      <= dir_nxt;
            chop_cnt_r <= chop_nxt;
            pend_r     <= pend_nxt;
        end
    end

    // Output flops and pin synchroniser
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_r  <= ZERO16;
            irq_r      <= 1'b0;
            chop_clk_r <= 1'b0;
            sevt_r2    <= 1'b0;
            bnd_r      <= 1'b0;
            cam_r      <= 1'b0;
            act_r      <= '0;
            dt_r       <= '0;
            cmp_s1_r   <= 1'b0;
            cmp_s2_r   <= 1'b0;
        end else begin
            rd_data_r  <= rd_nxt;
            irq_r      <= irq_nxt;
            chop_clk_r <= chop_lvl;
            sevt_r2    <= sevt_nxt;
            bnd_r      <= bnd_nxt;
            cam_r      <= cam_eff;
            if (upd) act_r <= act_nxt;
            dt_r       <= dt_nxt;
            cmp_s1_r   <= deadtime_comp_input;
            cmp_s2_r   <= cmp_s1_r;
        end
    end

    assign rd_data     = rd_data_r;
    assign irq         = irq_r;
    assign chop_clk    = chop_clk_r;
    assign sevt_match  = sevt_r2;
    assign period_bnd  = bnd_r;
    assign center_mode = cam_r;
    assign gen_count   = gcnt_r;
    assign act         = act_r;
    assign dt_ctl      = dt_r;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_gctl_off(int b);
        wr_gctl && !wr_data[b];
    endsequence

    fault_clear_a: assert property (s_gctl_off(B_FLT_E) ##0 !fault_evt |=> !pend_r[2]) // [R06]
        else $error("fault flag not cleared");
    fault_set_a: assert property (fault_evt |=> pend_r[2]) // [R06]
        else $error("fault event lost");
    limit_set_a: assert property (curlimit_evt |=> pend_r[1]) // [R07]
        else $error("current-limit event lost");
    trig_gate_a: assert property (trigger_evt && !ien[0] && !pend_r[0] |=> !pend_r[0]) // [R08]
        else $error("trigger set while disabled");
    irq_level_a: assert property (irq == |(pend_r & ien)) // [R22]
        else $error("irq does not follow flags");
    sevt_hit_a: assert property (tick && mtb_r == sevt_r |=> sevt_match) // [R02]
        else $error("special event match missed");
    period_wrap_a: assert property (!independent_period_mode && tick && mtb_r >= period_r |=> mtb_r == 16'h0) // [R01]
        else $error("master time base did not wrap");
    chop_stop_a: assert property (!chop_r[B_EN] |=> !chop_clk) // [R03]
        else $error("chop runs while disabled");
    duty_sel_a: assert property (gctl_r[B_IUE] && mod_en && gctl_r[B_DUTY_SOURCE_SELECT] && !wr_mduty
                                 |=> act.duty == mduty_r) // [R05]
        else $error("shared duty not selected");
    comp_gate_a: assert property (dtm != DTM_COMP |=> !dt_ctl.shorten_high && !dt_ctl.shorten_low) // [R13]
        else $error("compensation active outside mode");
    cam_gate_a: assert property (!independent_period_mode |=> !center_mode) // [R15]
        else $error("center mode without independent base");
    xres_a: assert property (mod_en && xreset |=> gen_count == 16'h0) // [R16]
        else $error("external reset ignored");
    rsvd_rd_a: assert property (rd_stb && addr == ADDR_GCTL |=> rd_data[4:3] == 2'h0) // [R19]
        else $error("reserved bits read nonzero");
    held_a: assert property (!mod_en |=> mtb_r == 16'h0 && pre_cnt_r == 7'h0) // [R20]
        else $error("time base runs while disabled");
endmodule : ptbg_core

// [ptbg_gate_model.sv]
/*
 * Gate driver and load model on the far side of the pwm outputs.
 * Assumes the bench sets the load current direction and overcurrent level.
 */
`timescale 1ns/1ps
module ptbg_gate_model (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // Load state set by the bench
    input  wire logic cur_dir,
    input  wire logic overcur,
    // Sensed levels back to the core
    output logic      deadtime_comp_input,
    output logic      curlimit_src
);
    // Sense comparators settle one clock after the load changes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            deadtime_comp_input <= 1'b0;
            curlimit_src        <= 1'b0;
        end else begin
            deadtime_comp_input <= cur_dir;
            curlimit_src        <= overcur;
        end
    end
endmodule : ptbg_gate_model

// [ptbg_pkg.sv]
/*
 * Constants, register map and carrier types of the pwm time base core.
 * Assumes one 100 MHz clock and a plain register port with 4-bit word index.
 */
package ptbg_pkg;
    localparam int          AW              = 4;
    localparam int          DW              = 16;
    // Register indices
    localparam logic [3:0]  ADDR_PERIOD     = 4'h0;
    localparam logic [3:0]  ADDR_SEVT       = 4'h1;
    localparam logic [3:0]  ADDR_CHOP       = 4'h2;
    localparam logic [3:0]  ADDR_MDUTY      = 4'h3;
    localparam logic [3:0]  ADDR_GCTL       = 4'h4;
    localparam logic [3:0]  ADDR_MCTL       = 4'h5;
    localparam logic [3:0]  ADDR_GDUTY      = 4'h6;
    localparam logic [3:0]  ADDR_PHASE      = 4'h7;
    localparam logic [3:0]  ADDR_DT         = 4'h8;
    localparam logic [3:0]  ADDR_ALTDT      = 4'h9;
    localparam logic [3:0]  ADDR_TBCNT      = 4'ha;
    // Reset values
    localparam logic [15:0] PERIOD_RST      = 16'hfff8;
    localparam logic [15:0] ZERO16          = 16'h0000;
    // Write masks (unimplemented and hardware-owned bits excluded)
    localparam logic [15:0] CHOP_WMASK      = 16'h83ff;
    localparam logic [15:0] GCTL_WMASK      = 16'h1fe7;
    localparam logic [15:0] DT_WMASK        = 16'h3fff;
    localparam logic [15:0] MCTL_WMASK      = 16'h8007;
    // Field positions
    localparam int          B_EN            = 15;
    localparam int          B_FLT_P         = 15;
    localparam int          B_CL_P          = 14;
    localparam int          B_TRG_P         = 13;
    localparam int          B_FLT_E         = 12;
    localparam int          B_CL_E          = 11;
    localparam int          B_TRG_E         = 10;
    localparam int          B_ITB           = 9;
    localparam int          B_DUTY_SOURCE_SELECT          = 8;
    localparam int          B_DTM_HI        = 7;
    localparam int          B_DTM_LO        = 6;
    localparam int          B_DEADTIME_COMP_POLARITY          = 5;
    localparam int          B_CAM           = 2;
    localparam int          B_EXTERNAL_PERIOD_RESET_ENABLE         = 1;
    localparam int          B_IUE           = 0;
    // Dead-time modes
    localparam logic [1:0]  DTM_POS         = 2'h0;
    localparam logic [1:0]  DTM_NEG         = 2'h1;
    localparam logic [1:0]  DTM_OFF         = 2'h2;
    localparam logic [1:0]  DTM_COMP        = 2'h3;
    localparam logic [2:0]  PRE_RSVD        = 3'h7;

    typedef struct packed {
        logic [15:0] period;
        logic [15:0] duty;
        logic [15:0] phase;
        logic [15:0] deadtime;
        logic [15:0] alt_deadtime;
    } ptbg_act_t;

    typedef struct packed {
        logic [1:0]  mode;
        logic        shorten_high;
        logic        shorten_low;
    } ptbg_dt_t;

    typedef enum logic [1:0] {
        CNT_UP   = 2'b01,
        CNT_DOWN = 2'b10
    } ptbg_dir_t;
endpackage : ptbg_pkg

// [tb_top.sv]
/*
 * Self-checking bench for the pwm time base core.
 * Assumes a 100 MHz clock and the gate driver model beside the core.
 */
`timescale 1ns/1ps
module tb_top import ptbg_pkg::*;;
    logic          ref_clk, nrst, wr_stb, rd_stb;
    logic [AW-1:0] addr;
    logic [DW-1:0] wr_data, rd_data;
    logic          fault_evt, curlimit_evt, trigger_evt, curlimit_mode;
    logic          curlimit_src, deadtime_comp_input, cur_dir, overcur;
    logic          irq, chop_clk, sevt_match, period_bnd, center_mode;
    logic [15:0]   gen_count;
    ptbg_act_t     act;
    ptbg_dt_t      dt_ctl;
    int            errors, checks_done;

    ptbg_core i_dut (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .fault_evt(fault_evt),
        .curlimit_evt(curlimit_evt), .trigger_evt(trigger_evt),
        .curlimit_src(curlimit_src), .curlimit_mode(curlimit_mode),
        .deadtime_comp_input(deadtime_comp_input), .irq(irq), .chop_clk(chop_clk),
        .sevt_match(sevt_match), .period_bnd(period_bnd), .center_mode(center_mode),
        .gen_count(gen_count), .act(act), .dt_ctl(dt_ctl));

    ptbg_gate_model i_drv (.ref_clk(ref_clk), .nrst(nrst), .cur_dir(cur_dir),
        .overcur(overcur), .deadtime_comp_input(deadtime_comp_input),
        .curlimit_src(curlimit_src));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic give_verdict;
        $display("Counts: %0d checks, %0d errors", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge ref_clk);
        wr_stb  <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        d = rd_data;
    endtask : rd

    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk("register read", exp, d);
    endtask : rdchk

    // Single-cycle event pulse; returns just after the sampling edge
    task automatic evt(input int s);
        @(posedge ref_clk);
        fault_evt    <= (s == 0);
        curlimit_evt <= (s == 1);
        trigger_evt  <= (s == 2);
        @(posedge ref_clk);
        fault_evt    <= 1'b0;
        curlimit_evt <= 1'b0;
        trigger_evt  <= 1'b0;
        #1;
    endtask : evt

    // Cycles until sevt_match (0) or period_bnd (1) is seen high
    task automatic wait_hi(input int sel, output int n);
        n = 0;
        do begin
            tick(1);
            n++;
            if (n > 3000) begin
                errors++;
                $display("CHECK FAILED pulse wait expected 1 seen 0");
                give_verdict();
            end
        end while (((sel == 0) ? sevt_match : period_bnd) !== 1'b1);
    endtask : wait_hi

    task automatic samp(output logic [15:0] s);
        for (int i = 0; i < 16; i++) begin
            tick(1);
            s[i] = chop_clk;
        end
    endtask : samp

    task automatic t_regs;
        for (int a = 0; a < 11; a++) begin
            rdchk(4'(a), (a == 0) ? PERIOD_RST : ZERO16);
        end
        wr(ADDR_PERIOD, 16'h1234);
        wr(ADDR_SEVT, 16'ha5a5);
        rdchk(ADDR_PERIOD, 16'h1234);
        rdchk(ADDR_SEVT, 16'ha5a5);
        wr(ADDR_CHOP, 16'hffff);
        rdchk(ADDR_CHOP, 16'h83ff);
        wr(ADDR_GCTL, 16'hffff);
        rdchk(ADDR_GCTL, 16'h1fe7);
        wr(4'hb, 16'hffff);
        rdchk(4'hb, ZERO16);
        wr(ADDR_CHOP, 16'h0000);
        wr(ADDR_GCTL, 16'h0000);
    endtask : t_regs

    task automatic t_events;
        evt(0);
        chk("irq masked", 16'h0, 16'(irq));
        wr(ADDR_GCTL, 16'h1c00);
        evt(0);
        chk("irq fault", 16'h1, 16'(irq));
        rdchk(ADDR_GCTL, 16'h9c00);
        wr(ADDR_GCTL, 16'h0c00);
        rdchk(ADDR_GCTL, 16'h0c00);
        chk("irq cleared", 16'h0, 16'(irq));
        evt(1);
        chk("irq limit", 16'h1, 16'(irq));
        rdchk(ADDR_GCTL, 16'h4c00);
        wr(ADDR_GCTL, 16'h0400);
        rdchk(ADDR_GCTL, 16'h0400);
        wr(ADDR_GCTL, 16'h0000);
        evt(2);
        rdchk(ADDR_GCTL, 16'h0000);
        wr(ADDR_GCTL, 16'h0400);
        evt(2);
        chk("irq trigger", 16'h1, 16'(irq));
        rdchk(ADDR_GCTL, 16'h2400);
        wr(ADDR_GCTL, 16'h0000);
        rdchk(ADDR_GCTL, 16'h0000);
    endtask : t_events

    task automatic t_modes;
        wr(ADDR_MDUTY, 16'h1234);
        wr(ADDR_GDUTY, 16'h5678);
        wr(ADDR_PHASE, 16'h0040);
        wr(ADDR_PERIOD, 16'h0100);
        wr(ADDR_GCTL, 16'h0004);
        tick(3);
        chk("own duty", 16'h5678, act.duty);
        chk("master period", 16'h0100, act.period);
        chk("cam ignored", 16'h0, 16'(center_mode));
        wr(ADDR_GCTL, 16'h0304);
        tick(3);
        chk("shared duty", 16'h1234, act.duty);
        chk("own period", 16'h0040, act.period);
        chk("center", 16'h1, 16'(center_mode));
        wr(ADDR_DT, 16'hffff);
        wr(ADDR_ALTDT, 16'h5555);
        tick(1);
        chk("active deadtime", 16'h3fff, act.deadtime);
        chk("active alt deadtime", 16'h1555, act.alt_deadtime);
        chk("active phase", 16'h0040, act.phase);
    endtask : t_modes

    task automatic t_deadtime;
        logic [3:0] sv [4][2];
        for (int m = 0; m < 4; m++) begin
            for (int p = 0; p < 2; p++) begin
                for (int i = 0; i < 2; i++) begin
                    cur_dir <= i[0];
                    wr(ADDR_GCTL, {8'h00, 2'(m), 1'(p), 5'h00});
                    tick(5);
                    chk("dt mode", 16'(m), 16'(dt_ctl.mode));
                    if (m == 3) begin
                        chk("short low", 16'(p[0] ^ i[0]), 16'(dt_ctl.shorten_low));
                        chk("short high", 16'(!(p[0] ^ i[0])), 16'(dt_ctl.shorten_high));
                    end else if (p == 0) begin
                        sv[m][i] = dt_ctl;
                    end else begin
                        chk("polarity ignored", 16'(sv[m][i]), 16'(dt_ctl));
                    end
                end
            end
        end
    endtask : t_deadtime

    task automatic t_timebase;
        int          n;
        logic [2:0]  code [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
        wr(ADDR_PERIOD, 16'h0004);
        wr(ADDR_SEVT, 16'h0002);
        wr(ADDR_GDUTY, 16'h0011);
        wr(ADDR_GCTL, 16'h0000);
        wr(ADDR_MCTL, 16'h8000);
        wait_hi(1, n);
        wr(ADDR_GDUTY, 16'h0022);
        chk("held duty", 16'h0011, act.duty);
        wait_hi(1, n);
        tick(1);
        chk("boundary duty", 16'h0022, act.duty);
        wr(ADDR_MCTL, 16'h0000);
        wr(ADDR_GCTL, 16'h0101);
        wr(ADDR_MCTL, 16'h8000);
        wr(ADDR_MDUTY, 16'h0033);
        tick(1);
        chk("immediate duty", 16'h0033, act.duty);
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_MCTL, {13'h1000, code[k]});
            wait_hi(0, n);
            wait_hi(0, n);
            chk("match spacing", 16'(5 << ((code[k] == 3'h7) ? 0 : code[k])), 16'(n));
        end
    endtask : t_timebase

    task automatic t_chop;
        logic [15:0] s;
        wr(ADDR_MCTL, 16'h8000);
        wr(ADDR_CHOP, 16'h8003);
        tick(8);
        samp(s);
        chk("chop high", 16'd8, 16'($countones(s)));
        chk("chop edges", 16'd4, 16'($countones(s & ~{s[14:0], s[15]})));
        wr(ADDR_CHOP, 16'h0003);
        tick(2);
        samp(s);
        chk("chop stopped", 16'h0, s);
    endtask : t_chop

    task automatic t_xres;
        logic [15:0] c;
        wr(ADDR_MCTL, 16'h0000);
        wr(ADDR_PHASE, 16'h0010);
        wr(ADDR_GCTL, 16'h0203);
        curlimit_mode <= 1'b0;
        wr(ADDR_MCTL, 16'h8000);
        tick(20);
        overcur <= 1'b1;
        tick(4);
        chk("count reset", 16'h0, gen_count);
        tick(2);
        chk("count held", 16'h0, gen_count);
        @(posedge ref_clk);
        curlimit_mode <= 1'b1;
        tick(3);
        c = gen_count;
        tick(1);
        chk("limit mode blocks reset", 16'h1, 16'(c !== gen_count));
        wr(ADDR_GCTL, 16'h0201);
        curlimit_mode <= 1'b0;
        tick(3);
        c = gen_count;
        tick(1);
        chk("count runs", 16'h1, 16'(c !== gen_count));
        overcur <= 1'b0;
    endtask : t_xres

    initial begin
        errors        = 0;
        checks_done   = 0;
        nrst          = 1'b0;
        addr          = '0;
        wr_data       = '0;
        wr_stb        = 1'b0;
        rd_stb        = 1'b0;
        fault_evt     = 1'b0;
        curlimit_evt  = 1'b0;
        trigger_evt   = 1'b0;
        curlimit_mode = 1'b0;
        cur_dir       = 1'b0;
        overcur       = 1'b0;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        t_regs();
        t_events();
        t_modes();
        t_deadtime();
        t_timebase();
        t_chop();
        t_xres();
        give_verdict();
    end
endmodule : tb_top
